// ===== bench/gated_sixteen_bit_timer_tb_top.sv
// Self-checking bench for the gated 16-bit timer
// Assumes pin_source and the checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`include "timer_one_regs.vh"
module gated_sixteen_bit_timer_tb_top;
  logic        i_clk, i_arst_n, i_wr, i_rd, i_sleep, i_internal_oscillator;
  logic [7:0]  i_addr, i_wdata, o_rdata, d;
  logic        o_lp_osc_run, o_wake, o_irq, cnt_pin, gate_pin, cmp_out;
  logic [15:0] cnt, base;
  logic [12:0] row;
  int          fail_count, checked, i;
  logic [7:0]  addrs [8] = '{`ADDR_CONTROL, `ADDR_COUNT_LOW, `ADDR_COUNT_HIGH, `ADDR_FLAGS,
                             `ADDR_ENABLES, `ADDR_INT_CTRL, `ADDR_GATE_SEL, 8'h55};
  logic [12:0] rows [9] = '{13'h0868, 13'h0865, 13'h1869, 13'h1878, 13'h0879, 13'h006d, 13'h0840,
                            13'h00e3, 13'h0062};
  gated_sixteen_bit_timer gated_sixteen_bit_timer_i
  (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_external_count_input(cnt_pin), .i_gate_pin(gate_pin),
    .i_comparator_two_output(cmp_out), .i_lp_osc_clk(cnt_pin), .i_internal_oscillator_no_clock_output(i_internal_oscillator),
    .i_sleep(i_sleep), .o_lp_osc_run(o_lp_osc_run), .o_wake(o_wake), .o_irq(o_irq)
  );
  pin_source pin_source_i (.i_clk(i_clk), .o_count_pin(cnt_pin), .o_gate_pin(gate_pin), .o_cmp_out(cmp_out));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic rdcnt(output logic [15:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(`ADDR_COUNT_LOW, lo);
    rd(`ADDR_COUNT_HIGH, hi);
    c = {hi, lo};
  endtask
  task automatic clear_count(input logic [15:0] v);
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_COUNT_LOW, v[7:0]);
    wr(`ADDR_COUNT_HIGH, v[15:8]);
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge i_clk);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    {i_arst_n, i_wr, i_rd, i_sleep, i_internal_oscillator, i_addr, i_wdata} = '0;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    base = 16'($urandom(79));
    for (i = 0; i < 8; i++)
    begin
      rd(addrs[i], d);
      check(16'(d), 16'h0000);
    end
    for (i = 0; i < 4; i++)
    begin
      base = 16'($urandom);
      clear_count(base);
      wr(`ADDR_CONTROL, {2'b00, i[1:0], 4'h3});
      pin_source_i.pulses(9);
      rdcnt(cnt);
      check(cnt, 16'(base + (8 >> i)));
    end
    for (i = 0; i < 9; i++)
    begin
      row = rows[i];
      clear_count(16'h0000);
      wr(`ADDR_GATE_SEL, {7'h00, row[4]});
      pin_source_i.set_levels(row[3], row[2]);
      i_sleep <= row[1];
      wr(`ADDR_CONTROL, row[12:5]);
      pin_source_i.pulses(5);
      rdcnt(cnt);
      check(cnt, row[0] ? 16'h0004 : 16'h0000);
    end
    i_sleep <= 1'b0;
    clear_count(16'h0000);
    wr(`ADDR_CONTROL, 8'h01);
    repeat (80) @(posedge i_clk);
    wr(`ADDR_CONTROL, 8'h00);
    rdcnt(cnt);
    check(16'(cnt >= 16'd19 && cnt <= 16'd21), 16'h0001);
    wr(`ADDR_FLAGS, 8'h01);
    clear_count(16'hfffe);
    wr(`ADDR_CONTROL, 8'h03);
    pin_source_i.pulses(3);
    rdcnt(cnt);
    check(cnt, 16'h0000);
    rd(`ADDR_FLAGS, d);
    check(16'(d[0]), 16'h0001);
    for (i = 0; i < 8; i++)
    begin
      wr(`ADDR_ENABLES, {7'h00, i[0]});
      wr(`ADDR_INT_CTRL, {i[2:1], 6'h00});
      check(16'(o_irq), 16'(i == 7));
      check(16'(o_wake), 16'(i[0]));
    end
    wr(`ADDR_FLAGS, 8'h01);
    check(16'(o_irq), 16'h0000);
    i_internal_oscillator <= 1'b1;
    wr(`ADDR_CONTROL, 8'h08);
    check(16'(o_lp_osc_run), 16'h0001);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== bench/pin_source.sv
// Pin-side model: count clock pulses, gate levels
// Assumes the bench calls its tasks in sequence
`timescale 1ns/1ns
`default_nettype none
module pin_source
(
  input  wire logic i_clk,
  output var  logic o_count_pin,
  output var  logic o_gate_pin,
  output var  logic o_cmp_out
);
  initial
  begin
    o_count_pin = 1'b0;
    o_gate_pin  = 1'b0;
    o_cmp_out   = 1'b0;
  end
  // Parked low, each pulse rises then falls
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_count_pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_count_pin <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
  task automatic set_levels(input logic gp, input logic cp);
    @(posedge i_clk);
    o_gate_pin <= gp;
    o_cmp_out  <= cp;
  endtask
endmodule
`default_nettype wire

// ===== bench/timer_asserts.sv
// Port checker for the gated 16-bit timer
// Assumes binding onto gated_sixteen_bit_timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_one_regs.vh"
module timer_asserts
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_internal_oscillator_no_clock_output,
  input wire logic       o_lp_osc_run,
  input wire logic       o_wake,
  input wire logic       o_irq
);
  logic [7:0] ctl_q;
  logic       oven_q;
  logic [1:0] ie_q;
  logic       mapped;
  assign mapped = i_addr == `ADDR_COUNT_LOW || i_addr == `ADDR_COUNT_HIGH || i_addr == `ADDR_CONTROL ||
                  i_addr == `ADDR_FLAGS || i_addr == `ADDR_ENABLES || i_addr == `ADDR_INT_CTRL ||
                  i_addr == `ADDR_GATE_SEL;
  always @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      ctl_q  <= 8'h00;
      oven_q <= 1'b0;
      ie_q   <= 2'h0;
    end
    else if (i_wr)
    begin
      if (i_addr == `ADDR_CONTROL) ctl_q <= i_wdata;
      if (i_addr == `ADDR_ENABLES) oven_q <= i_wdata[0];
      if (i_addr == `ADDR_INT_CTRL) ie_q <= i_wdata[7:6];
    end
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  a_ctrl_readback: assert property (i_rd && i_addr == `ADDR_CONTROL |=> o_rdata == $past(ctl_q))
    else $error("control readback wrong");
  a_unmapped_zero: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_all_enables: assert property (o_irq |-> oven_q && ie_q == 2'h3)
    else $error("interrupt without all enables");
  a_irq_needs_wake: assert property (o_irq |-> o_wake)
    else $error("interrupt without flagged wake");
  a_wake_masked: assert property (o_wake |-> oven_q)
    else $error("wake without enable");
  a_irq_sticky: assert property (o_irq && !i_wr |=> o_irq)
    else $error("interrupt dropped without write");
  a_lp_osc_run: assert property (o_lp_osc_run == (ctl_q[3] && i_internal_oscillator_no_clock_output))
    else $error("oscillator run wrong");
  c_irq: cover property ($rose(o_irq));
  c_wake: cover property ($rose(o_wake));
  c_ctrl_read: cover property (i_rd && i_addr == `ADDR_CONTROL);
endmodule
bind gated_sixteen_bit_timer timer_asserts timer_asserts_i
(
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_internal_oscillator_no_clock_output(i_internal_oscillator_no_clock_output),
  .o_lp_osc_run(o_lp_osc_run), .o_wake(o_wake), .o_irq(o_irq)
);
`default_nettype wire

// ===== logic/edge_sync.v
// Two-stage synchroniser with registered rise and fall pulses
// Assumes input from outside the i_clk domain
`timescale 1ns/1ns
`default_nettype none

module edge_sync
(
  input  wire i_clk,
  input  wire i_arst_n,
  input  wire i_async,
  output wire o_level,
  output reg  o_rise,
  output reg  o_fall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  assign o_level = sync_q;

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
      o_rise <= sync_q & ~prev_q;
      o_fall <= ~sync_q & prev_q;
    end
  end

endmodule

`default_nettype wire

// ===== logic/gated_sixteen_bit_timer.v
// Gated 16-bit timer/counter with prescaler, gate and overflow interrupt
// Assumes one 100 MHz clock; pins and oscillator are sampled in here
//
// Summary of operation
// - Count upward, wrap, set overflow flag
// - Interrupt needs peripheral, global, overflow enables
// - Timer mode counts each instruction cycle
// - Counter mode counts external rising edges
// - Counter mode synchronous or asynchronous
// - First falling edge precedes any counter mode count
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler hidden, cleared by count writes
// - Gate from pin or comparator two
// - Gating only while gate enable set
// - Gate invert bit flips gate sense
// - Low-power oscillator may clock counter
// - Asynchronous counting continues during sleep, wakes
// - Prescale codes 00,01,10,11 map 1,2,4,8
// - Gate enable ignored while timer off
// - Sync disable still synchronises external clock; only lets it count in sleep
`timescale 1ns/1ns
`default_nettype none
`include "timer_one_regs.vh"

module gated_sixteen_bit_timer
#(
  parameter INSTR_DIV = 4
)
(
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_external_count_input,
  input  wire       i_gate_pin,
  input  wire       i_comparator_two_output,
  input  wire       i_lp_osc_clk,
  input  wire       i_internal_oscillator_no_clock_output,
  input  wire       i_sleep,
  output wire       o_lp_osc_run,
  output wire       o_wake,
  output wire       o_irq
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0]  control_q;
  reg  [15:0] count_q;
  reg  [15:0] count_d;
  reg  [2:0]  prescale_q;
  reg         overflow_flag_q;
  reg         overflow_en_q;
  reg  [1:0]  int_ctrl_q;
  reg         gate_source_select_q;
  reg         armed_q;
  reg  [1:0]  icyc_q;
  reg         wrap;

  wire timer_on     = control_q[`CTL_TIMER_ON];
  wire clk_src      = control_q[`CTL_CLK_SRC];
  wire sync_disable = control_q[`CTL_SYNC_DIS];
  wire lp_osc_en    = control_q[`CTL_LP_OSC_EN];
  wire [1:0] prescale_select = control_q[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
  wire gate_enable  = control_q[`CTL_GATE_EN];
  wire gate_invert  = control_q[`CTL_GATE_INV];

  wire wr_low  = i_wr && (i_addr == `ADDR_COUNT_LOW);
  wire wr_high = i_wr && (i_addr == `ADDR_COUNT_HIGH);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire ext_level;
  wire ext_rise;
  wire ext_fall;
  wire lp_level;
  wire lp_rise;
  wire lp_fall;
  wire gpin_level;
  wire cmp_level;

  // Low-power oscillator used only with internal oscillator, no clock out
  // Oscillator source select
  assign o_lp_osc_run = lp_osc_en && i_internal_oscillator_no_clock_output;
  wire ext_src = o_lp_osc_run ? i_lp_osc_clk : i_external_count_input;

  edge_sync u_ext
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (ext_src),
    .o_level  (ext_level),
    .o_rise   (ext_rise),
    .o_fall   (ext_fall)
  );

  edge_sync u_gpin
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_gate_pin),
    .o_level  (gpin_level),
    .o_rise   (),
    .o_fall   ()
  );

  edge_sync u_cmp
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_comparator_two_output),
    .o_level  (cmp_level),
    .o_rise   (),
    .o_fall   ()
  );

  assign lp_level = ext_level;
  assign lp_rise  = ext_rise;
  assign lp_fall  = ext_fall;

  // ---------------------------------------------------------------
  // Gate
  // ---------------------------------------------------------------
  // Gate source choice
  wire gate_raw = gate_source_select_q ? cmp_level : gpin_level;
  wire gate_open = gate_invert ? gate_raw : ~gate_raw;
  wire gate_ok = ~(timer_on && gate_enable) | gate_open;

  // ---------------------------------------------------------------
  // Clock tick selection
  // ---------------------------------------------------------------
  // Instruction cycle strobe, one per INSTR_DIV clocks
  wire icyc_tick = (icyc_q == INSTR_DIV[1:0] - 2'd1);

  // Asynchronous mode: edge taken from synchronised level, not gated by sleep
  // Sync or async select
  wire ext_tick = armed_q && lp_rise && (sync_disable || !i_sleep);

  wire src_tick = clk_src ? ext_tick : (icyc_tick && !i_sleep);

  wire pre_tick = timer_on && gate_ok && src_tick;

  reg [2:0] pre_max;
  always @*
  begin
    case (prescale_select)
      2'b00:   pre_max = 3'd0;
      2'b01:   pre_max = 3'd1;
      2'b10:   pre_max = 3'd3;
      default: pre_max = 3'd7;
    endcase
  end

  wire inc = pre_tick && (prescale_q >= pre_max);

  // ---------------------------------------------------------------
  // Counter state
  // ---------------------------------------------------------------
  always @*
  begin
    count_d = count_q;
    wrap    = 1'b0;
    if (wr_low)
      count_d[7:0] = i_wdata;
    else if (wr_high)
      count_d[15:8] = i_wdata;
    else if (inc)
    begin
      count_d = count_q + 16'd1;
      wrap    = (count_q == 16'hffff);
    end
  end

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_q    <= `COUNT_RESET;
      prescale_q <= 3'd0;
      armed_q    <= 1'b0;
      icyc_q     <= 2'd0;
    end
    else
    begin
      count_q <= count_d;
      icyc_q  <= icyc_tick ? 2'd0 : icyc_q + 2'd1;
      if (wr_low || wr_high)
        prescale_q <= 3'd0;
      else if (pre_tick)
        prescale_q <= (prescale_q >= pre_max) ? 3'd0 : prescale_q + 3'd1;
      if (!clk_src || !timer_on)
        armed_q <= 1'b0;
      else if (lp_fall || (armed_q == 1'b0 && !lp_level && ext_fall))
        armed_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control and interrupt registers
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      control_q            <= `CONTROL_RESET;
      overflow_flag_q      <= 1'b0;
      overflow_en_q        <= 1'b0;
      int_ctrl_q           <= 2'b00;
      gate_source_select_q <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == `ADDR_CONTROL)
        control_q <= i_wdata;
      if (i_wr && i_addr == `ADDR_ENABLES)
        overflow_en_q <= i_wdata[`FLAG_OVERFLOW];
      if (i_wr && i_addr == `ADDR_INT_CTRL)
        int_ctrl_q <= i_wdata[`INT_GLOBAL_EN:`INT_PERIPH_EN];
      if (i_wr && i_addr == `ADDR_GATE_SEL)
        gate_source_select_q <= i_wdata[`GSEL_SOURCE];
      if (wrap)
        overflow_flag_q <= 1'b1;
      else if (i_wr && i_addr == `ADDR_FLAGS && i_wdata[`FLAG_OVERFLOW])
        overflow_flag_q <= 1'b0;
    end
  end

  assign o_irq = overflow_flag_q && overflow_en_q && int_ctrl_q[1] && int_ctrl_q[0];

  assign o_wake = overflow_flag_q && overflow_en_q;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      if (i_addr == `ADDR_COUNT_LOW)
        o_rdata <= count_q[7:0];
      else if (i_addr == `ADDR_COUNT_HIGH)
        o_rdata <= count_q[15:8];
      else if (i_addr == `ADDR_CONTROL)
        o_rdata <= control_q;
      else if (i_addr == `ADDR_FLAGS)
        o_rdata <= {7'h00, overflow_flag_q};
      else if (i_addr == `ADDR_ENABLES)
        o_rdata <= {7'h00, overflow_en_q};
      else if (i_addr == `ADDR_INT_CTRL)
        o_rdata <= {int_ctrl_q, 6'h00};
      else if (i_addr == `ADDR_GATE_SEL)
        o_rdata <= {7'h00, gate_source_select_q};
      else
        o_rdata <= 8'h00;
    end
    else
      o_rdata <= 8'h00;
  end

endmodule

`default_nettype wire

// ===== shared/timer_one_regs.vh
// Register offsets, field positions, reset values for the gated 16-bit timer
// Included by the timer design files; defines only
`ifndef TIMER_ONE_REGS_VH
`define TIMER_ONE_REGS_VH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define ADDR_COUNT_LOW      8'h0e
`define ADDR_COUNT_HIGH     8'h0f
`define ADDR_CONTROL        8'h10
`define ADDR_FLAGS          8'h0c
`define ADDR_ENABLES        8'h8c
`define ADDR_INT_CTRL       8'h0b
`define ADDR_GATE_SEL       8'h1a

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define CTL_TIMER_ON        0
`define CTL_CLK_SRC         1
`define CTL_SYNC_DIS        2
`define CTL_LP_OSC_EN       3
`define CTL_PRESCALE_LO     4
`define CTL_PRESCALE_HI     5
`define CTL_GATE_EN         6
`define CTL_GATE_INV        7

// ---------------------------------------------------------------
// Other fields and resets
// ---------------------------------------------------------------
`define FLAG_OVERFLOW       0
`define INT_PERIPH_EN       6
`define INT_GLOBAL_EN       7
`define GSEL_SOURCE         0
`define CONTROL_RESET       8'h00
`define COUNT_RESET         16'h0000

`endif
